// ### rtl/iatc_pkg.sv
`default_nettype none
package iatc_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NS_PER_US = 1000;
  localparam logic [4:0] CYC_PER_US = 5'(NS_PER_US / CLK_PERIOD_NS);
  localparam logic [32:0] CLK_HZ_W = 33'(CLK_HZ);
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_BURST = 8'h08;
  localparam logic [7:0] OFS_EXPO = 8'h0c;
  localparam logic [7:0] OFS_FRATE = 8'h10;
  localparam logic [7:0] OFS_ROWRATE = 8'h14;
  localparam logic [7:0] OFS_TRIG = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_ACHIEVED = 8'h20;
  // Control register fields
  localparam int unsigned CTRL_RUN_LSB = 0;
  localparam int unsigned CTRL_BOOT = 2;
  localparam int unsigned CTRL_TIMING = 3;
  localparam int unsigned CTRL_AUTO_LSB = 4;
  localparam int unsigned CTRL_RATE_EN = 6;
  localparam int unsigned CTRL_KIND = 7;
  localparam int unsigned CTRL_SHUTTER = 8;
  // Command register bits
  localparam int unsigned CMD_BEGIN = 0;
  localparam int unsigned CMD_END = 1;
  localparam int unsigned CMD_HOST_TRIG = 2;
  // Encodings
  localparam logic [1:0] RUN_CONT = 2'h0;
  localparam logic [1:0] RUN_MULTI = 2'h1;
  localparam logic [1:0] RUN_SINGLE = 2'h2;
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_ONCE = 2'h1;
  localparam logic [1:0] AUTO_CONT = 2'h2;
  localparam logic [2:0] SRC_SW = 3'h0;
  localparam logic [2:0] SRC_PIN_MAX = 3'h4;
  localparam logic [1:0] ACT_LOW = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_FALL = 2'h2;
  localparam logic [1:0] ACT_RISE = 2'h3;
  localparam logic KIND_ACQ = 1'b0;
  localparam logic KIND_IMG = 1'b1;
  // Reset values and frame geometry
  localparam logic [31:0] BURST_RST = 32'h0000_0001;
  localparam logic [31:0] EXPO_RST = 32'h0000_03e8;
  localparam logic [31:0] FRATE_RST = 32'h0000_001e;
  localparam logic [31:0] ROWRATE_RST = 32'h0001_86a0;
  localparam logic [15:0] ROWS_PER_FRAME = 16'h0010;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Per-kind trigger settings
  typedef struct packed {
    logic [1:0] cond;
    logic [2:0] origin;
    logic enable;
  } iatc_trig_cfg_t;
  localparam iatc_trig_cfg_t TRIG_CFG_RST = '{cond: 2'h3, origin: 3'h0, enable: 1'b0};
  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARMED = 5'h02,
    ST_WAIT = 5'h04,
    ST_EXPOSE = 5'h08,
    ST_READOUT = 5'h10
  } iatc_state_t;
endpackage : iatc_pkg
`default_nettype wire

// ### rtl/iatc_top.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
module iatc_top #(
  parameter logic P_START_AT_POWERUP = 1'b0,
  parameter int unsigned P_RATE_WINDOW = 25_000_000
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [3:0] i_trig_line,
  output logic o_acquiring,
  output logic o_exposing,
  output logic o_row_strobe,
  output logic o_frame_done,
  output logic o_auto_active
);
  // Trigger hit for one kind; returns the event for the configured source
  function automatic logic trig_hit(input iatc_pkg::iatc_trig_cfg_t cfg, input logic sw,
                                    input logic [3:0] lvl, input logic [3:0] rise,
                                    input logic [3:0] fall);
    logic [1:0] idx;
    idx = 2'(cfg.origin - 3'h1);
    if (!cfg.enable || cfg.origin > iatc_pkg::SRC_PIN_MAX)
      trig_hit = 1'b0;
    else if (cfg.origin == iatc_pkg::SRC_SW)
      trig_hit = sw;
    else
    begin
      case (cfg.cond)
        iatc_pkg::ACT_LOW: trig_hit = !lvl[idx];
        iatc_pkg::ACT_HIGH: trig_hit = lvl[idx];
        iatc_pkg::ACT_FALL: trig_hit = fall[idx];
        default: trig_hit = rise[idx];
      endcase
    end
  endfunction : trig_hit

  // Pin in its asserted sense, used to time pulse-width exposure
  function automatic logic trig_level(input iatc_pkg::iatc_trig_cfg_t cfg,
                                      input logic [3:0] lvl);
    logic [1:0] idx;
    idx = 2'(cfg.origin - 3'h1);
    if (cfg.origin == iatc_pkg::SRC_SW || cfg.origin > iatc_pkg::SRC_PIN_MAX)
      trig_level = 1'b0;
    else if (cfg.cond == iatc_pkg::ACT_LOW || cfg.cond == iatc_pkg::ACT_FALL)
      trig_level = !lvl[idx];
    else
      trig_level = lvl[idx];
  endfunction : trig_level

  // Bus handshake state
  logic [7:0] aw_addr; // Held write address
  logic aw_full; // Write address captured
  logic [31:0] w_data; // Held write data
  logic w_full; // Write data captured
  logic wr_fire; // Both halves present: commit
  // Software settings
  logic [1:0] run_mode;
  logic start_at_powerup;
  logic timing_sel; // 0 timed, 1 pulse length
  logic [1:0] auto_sel;
  logic rate_en;
  logic kind_sel;
  logic [31:0] burst_total;
  logic [31:0] expo_us;
  logic [31:0] frame_rate;
  logic [31:0] row_rate;
  iatc_pkg::iatc_trig_cfg_t trig_cfg [2]; // Indexed by trigger kind
  // Command pulses
  logic cmd_begin;
  logic cmd_end;
  logic cmd_host_trig;
  logic boot_pend; // First cycle after reset
  // Pin synchronisers and detectors
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [1:0] hit; // Per-kind trigger events
  // Sequencer
  iatc_pkg::iatc_state_t state;
  logic [31:0] frames_left;
  logic [4:0] us_div;
  logic [31:0] us_cnt;
  logic expo_done;
  logic [32:0] frame_acc;
  logic pace_pend; // A pacing slot has elapsed
  logic [32:0] row_acc;
  logic row_tick;
  logic [15:0] row_cnt;
  // Rate measurement
  logic [31:0] win_cnt;
  logic [31:0] win_frames;
  logic [31:0] achieved;
  logic [31:0] next_rdata;
  logic next_rok;

  // Write channel capture; each half is taken independently
  assign wr_fire = aw_full && w_full && !o_s_axi_bvalid;
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= iatc_pkg::RESP_OKAY;
    end
    else
    begin
      o_s_axi_awready <= !aw_full && !(o_s_axi_awready && i_s_axi_awvalid);
      o_s_axi_wready <= !w_full && !(o_s_axi_wready && i_s_axi_wvalid);
      if (o_s_axi_awready && i_s_axi_awvalid)
      begin
        aw_full <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid)
      begin
        w_full <= 1'b1;
        w_data <= i_s_axi_wdata;
      end
      if (wr_fire)
      begin
        // Status and rate words are read-only: flag the write
        aw_full <= 1'b0;
        w_full <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (aw_addr[7:2] <= iatc_pkg::OFS_TRIG[7:2] && aw_addr[1:0] == 2'b00)
                         ? iatc_pkg::RESP_OKAY : iatc_pkg::RESP_SLVERR;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  // Settings; strobes ignored, every write is a full word
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      run_mode <= iatc_pkg::RUN_CONT;
      start_at_powerup <= P_START_AT_POWERUP;
      timing_sel <= 1'b0;
      auto_sel <= iatc_pkg::AUTO_OFF;
      rate_en <= 1'b0;
      kind_sel <= iatc_pkg::KIND_ACQ;
      burst_total <= iatc_pkg::BURST_RST;
      expo_us <= iatc_pkg::EXPO_RST;
      frame_rate <= iatc_pkg::FRATE_RST;
      row_rate <= iatc_pkg::ROWRATE_RST;
      trig_cfg[0] <= iatc_pkg::TRIG_CFG_RST;
      trig_cfg[1] <= iatc_pkg::TRIG_CFG_RST;
    end
    else
    begin
      if (o_frame_done && auto_sel == iatc_pkg::AUTO_ONCE)
        auto_sel <= iatc_pkg::AUTO_OFF;
      if (wr_fire)
      begin
        case (aw_addr)
          iatc_pkg::OFS_CTRL:
          begin
            run_mode <= w_data[iatc_pkg::CTRL_RUN_LSB +: 2];
            start_at_powerup <= w_data[iatc_pkg::CTRL_BOOT];
            timing_sel <= w_data[iatc_pkg::CTRL_TIMING];
            auto_sel <= w_data[iatc_pkg::CTRL_AUTO_LSB +: 2];
            rate_en <= w_data[iatc_pkg::CTRL_RATE_EN];
            kind_sel <= w_data[iatc_pkg::CTRL_KIND];
          end
          iatc_pkg::OFS_BURST: burst_total <= w_data;
          iatc_pkg::OFS_EXPO: expo_us <= w_data;
          iatc_pkg::OFS_FRATE: frame_rate <= w_data;
          iatc_pkg::OFS_ROWRATE: row_rate <= w_data;
          iatc_pkg::OFS_TRIG: trig_cfg[kind_sel] <= w_data[5:0];
          default: ;
        endcase
      end
    end
  end

  // Command strobes, one cycle each; boot start fires once after release
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cmd_begin <= 1'b0;
      cmd_end <= 1'b0;
      cmd_host_trig <= 1'b0;
      boot_pend <= 1'b1;
    end
    else
    begin
      boot_pend <= 1'b0;
      cmd_begin <= (wr_fire && aw_addr == iatc_pkg::OFS_CMD && w_data[iatc_pkg::CMD_BEGIN])
                   || (boot_pend && start_at_powerup);
      cmd_end <= wr_fire && aw_addr == iatc_pkg::OFS_CMD && w_data[iatc_pkg::CMD_END];
      cmd_host_trig <= wr_fire && aw_addr == iatc_pkg::OFS_CMD
                       && w_data[iatc_pkg::CMD_HOST_TRIG];
    end
  end

  // Pin synchronisers; only stage two onward feeds detection
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end
    else
    begin
      pin_s1 <= i_trig_line;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  assign pin_rise = pin_s2 & ~pin_s3;
  assign pin_fall = ~pin_s2 & pin_s3;

  // Trigger events per kind; host trigger goes only to the selected kind
  for (genvar k = 0; k < 2; k++)
  begin : g_hit
    assign hit[k] = trig_hit(trig_cfg[k], cmd_host_trig && kind_sel == 1'(k),
                             pin_s2, pin_rise, pin_fall);
  end

  // Microsecond base for exposure, restarted at each exposure start
  assign expo_done = timing_sel
                     ? !trig_level(trig_cfg[iatc_pkg::KIND_IMG], pin_s2)
                     : (us_div == iatc_pkg::CYC_PER_US - 5'h01
                        && us_cnt + 32'h1 >= expo_us);
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      us_div <= 5'h00;
      us_cnt <= 32'h0000_0000;
    end
    else if (state != iatc_pkg::ST_EXPOSE)
    begin
      us_div <= 5'h00;
      us_cnt <= 32'h0000_0000;
    end
    else if (us_div == iatc_pkg::CYC_PER_US - 5'h01)
    begin
      us_div <= 5'h00;
      us_cnt <= us_cnt + 32'h1;
    end
    else
      us_div <= us_div + 5'h01;
  end

  // Frame pacing accumulator; a slot seen mid-frame is held, not queued
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      frame_acc <= 33'h0;
      pace_pend <= 1'b0;
    end
    else if (state == iatc_pkg::ST_IDLE || state == iatc_pkg::ST_ARMED)
    begin
      frame_acc <= 33'h0;
      pace_pend <= 1'b1;
    end
    else
    begin
      if (frame_acc + {1'b0, frame_rate} >= iatc_pkg::CLK_HZ_W)
      begin
        frame_acc <= frame_acc + {1'b0, frame_rate} - iatc_pkg::CLK_HZ_W;
        pace_pend <= 1'b1;
      end
      else
      begin
        frame_acc <= frame_acc + {1'b0, frame_rate};
        if (state == iatc_pkg::ST_WAIT && state != iatc_pkg::ST_IDLE && pace_pend)
          pace_pend <= 1'b0;
      end
    end
  end

  // Row timing during readout; rates above the clock give one row per cycle
  assign row_tick = row_acc + {1'b0, row_rate} >= iatc_pkg::CLK_HZ_W;
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      row_acc <= 33'h0;
      row_cnt <= 16'h0000;
      o_row_strobe <= 1'b0;
    end
    else if (state != iatc_pkg::ST_READOUT)
    begin
      row_acc <= 33'h0;
      row_cnt <= 16'h0000;
      o_row_strobe <= 1'b0;
    end
    else if (row_cnt == iatc_pkg::ROWS_PER_FRAME)
      o_row_strobe <= 1'b0; // All rows strobed; no extra strobe while leaving readout
    else
    begin
      o_row_strobe <= row_tick;
      if (row_tick)
      begin
        row_acc <= row_acc + {1'b0, row_rate} - iatc_pkg::CLK_HZ_W;
        row_cnt <= row_cnt + 16'h0001;
      end
      else
        row_acc <= row_acc + {1'b0, row_rate};
    end
  end

  // Capture sequencer; end command overrides everything
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= iatc_pkg::ST_IDLE;
      frames_left <= 32'h0000_0000;
      o_frame_done <= 1'b0;
    end
    else
    begin
      o_frame_done <= 1'b0;
      if (cmd_end)
        state <= iatc_pkg::ST_IDLE;
      else
      begin
        case (state)
          iatc_pkg::ST_IDLE:
          begin
            if (cmd_begin)
            begin
              // Zero burst behaves as one image
              frames_left <= (run_mode == iatc_pkg::RUN_SINGLE || burst_total == 32'h0)
                             ? 32'h1 : burst_total;
              state <= trig_cfg[iatc_pkg::KIND_ACQ].enable
                       ? iatc_pkg::ST_ARMED : iatc_pkg::ST_WAIT;
            end
          end
          iatc_pkg::ST_ARMED:
            if (hit[iatc_pkg::KIND_ACQ])
              state <= iatc_pkg::ST_WAIT;
          iatc_pkg::ST_WAIT:
          begin
            if (trig_cfg[iatc_pkg::KIND_IMG].enable ? hit[iatc_pkg::KIND_IMG]
                : (!rate_en || pace_pend))
              state <= iatc_pkg::ST_EXPOSE;
          end
          iatc_pkg::ST_EXPOSE:
            if (expo_done)
              state <= iatc_pkg::ST_READOUT;
          iatc_pkg::ST_READOUT:
          begin
            if (row_cnt == iatc_pkg::ROWS_PER_FRAME)
            begin
              o_frame_done <= 1'b1;
              if (run_mode != iatc_pkg::RUN_MULTI && run_mode != iatc_pkg::RUN_SINGLE)
                state <= iatc_pkg::ST_WAIT;
              else if (frames_left <= 32'h1)
                state <= iatc_pkg::ST_IDLE;
              else
              begin
                frames_left <= frames_left - 32'h1;
                state <= iatc_pkg::ST_WAIT;
              end
            end
          end
          default: state <= iatc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Achieved rate: images finished per window; long exposures lower it
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      win_cnt <= 32'h0000_0000;
      win_frames <= 32'h0000_0000;
      achieved <= 32'h0000_0000;
    end
    else if (win_cnt == 32'(P_RATE_WINDOW - 1))
    begin
      win_cnt <= 32'h0000_0000;
      achieved <= win_frames + {31'h0, o_frame_done};
      win_frames <= 32'h0000_0000;
    end
    else
    begin
      win_cnt <= win_cnt + 32'h1;
      win_frames <= win_frames + {31'h0, o_frame_done};
    end
  end

  // Status outputs
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_acquiring <= 1'b0;
      o_exposing <= 1'b0;
      o_auto_active <= 1'b0;
    end
    else
    begin
      o_acquiring <= state != iatc_pkg::ST_IDLE;
      o_exposing <= state == iatc_pkg::ST_EXPOSE;
      o_auto_active <= auto_sel != iatc_pkg::AUTO_OFF;
    end
  end

  // Read data select; shutter style reads back its only value, global
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rok = 1'b1;
    case (i_s_axi_araddr)
      iatc_pkg::OFS_CTRL:
      begin
        next_rdata[iatc_pkg::CTRL_RUN_LSB +: 2] = run_mode;
        next_rdata[iatc_pkg::CTRL_BOOT] = start_at_powerup;
        next_rdata[iatc_pkg::CTRL_TIMING] = timing_sel;
        next_rdata[iatc_pkg::CTRL_AUTO_LSB +: 2] = auto_sel;
        next_rdata[iatc_pkg::CTRL_RATE_EN] = rate_en;
        next_rdata[iatc_pkg::CTRL_KIND] = kind_sel;
        next_rdata[iatc_pkg::CTRL_SHUTTER] = 1'b0;
      end
      iatc_pkg::OFS_CMD: next_rdata = 32'h0000_0000;
      iatc_pkg::OFS_BURST: next_rdata = burst_total;
      iatc_pkg::OFS_EXPO: next_rdata = expo_us;
      iatc_pkg::OFS_FRATE: next_rdata = frame_rate;
      iatc_pkg::OFS_ROWRATE: next_rdata = row_rate;
      iatc_pkg::OFS_TRIG: next_rdata = {26'h0, trig_cfg[kind_sel]};
      iatc_pkg::OFS_STATUS: next_rdata = {27'h0, state};
      iatc_pkg::OFS_ACHIEVED: next_rdata = achieved;
      default: next_rok = 1'b0;
    endcase
  end

  // Read channel: one outstanding read, answered the cycle after the address
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= iatc_pkg::RESP_OKAY;
    end
    else
    begin
      o_s_axi_arready <= !o_s_axi_rvalid && !(o_s_axi_arready && i_s_axi_arvalid);
      if (o_s_axi_arready && i_s_axi_arvalid)
      begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= next_rdata;
        o_s_axi_rresp <= next_rok ? iatc_pkg::RESP_OKAY : iatc_pkg::RESP_SLVERR;
      end
      else if (o_s_axi_rvalid && i_s_axi_rready)
        o_s_axi_rvalid <= 1'b0;
    end
  end

  // Exposure length counter, read only by a check below
  logic [31:0] expo_cyc;
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      expo_cyc <= 32'h0000_0000;
    else if (state == iatc_pkg::ST_EXPOSE)
      expo_cyc <= expo_cyc + 32'h1;
    else
      expo_cyc <= 32'h0000_0000;
  end

  stop_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_end |=> state == iatc_pkg::ST_IDLE ##1 !o_acquiring)
    else $error("end command did not stop capture");
  single_stop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_frame_done && run_mode == iatc_pkg::RUN_SINGLE) |-> state == iatc_pkg::ST_IDLE)
    else $error("single frame run kept going");
  cont_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_frame_done && run_mode == iatc_pkg::RUN_CONT && !$past(cmd_end))
    |-> state == iatc_pkg::ST_WAIT)
    else $error("continuous run stopped by itself");
  multi_count_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_frame_done && run_mode == iatc_pkg::RUN_MULTI && state == iatc_pkg::ST_WAIT)
    |-> frames_left == $past(frames_left) - 32'h1)
    else $error("burst count not stepped");
  timed_len_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == iatc_pkg::ST_EXPOSE && !timing_sel && expo_done && !cmd_end && expo_us != 0)
    |-> expo_cyc + 32'h1 == expo_us * 32'(iatc_pkg::CYC_PER_US))
    else $error("timed exposure length wrong");
  once_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_frame_done && auto_sel == iatc_pkg::AUTO_ONCE && !wr_fire) |=> auto_sel == iatc_pkg::AUTO_OFF)
    else $error("auto once did not return off");
  armed_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == iatc_pkg::ST_ARMED && !hit[iatc_pkg::KIND_ACQ] && !cmd_end)
    |=> state == iatc_pkg::ST_ARMED)
    else $error("capture began without start trigger");
  edge_single_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (pin_rise != 4'h0) |=> (pin_rise & $past(pin_rise)) == 4'h0)
    else $error("edge pulse longer than one cycle");
  host_only_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == iatc_pkg::ST_WAIT && trig_cfg[1].enable && trig_cfg[1].origin == 3'h0
     && !cmd_host_trig && !cmd_end) |=> state == iatc_pkg::ST_WAIT)
    else $error("image started without host trigger");
  pace_wait_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == iatc_pkg::ST_WAIT && !trig_cfg[1].enable && rate_en && !pace_pend && !cmd_end)
    |=> state == iatc_pkg::ST_WAIT)
    else $error("image started before pacing slot");
endmodule : iatc_top
`default_nettype wire

// ### testbench/iatc_top_test.sv
`default_nettype none
module iatc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Bus drive, trigger request and design outputs
  logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, fire = 0;
  logic awr, wr_r, bv, arr, rv, acq, expo, fdone, auto, rstb;
  logic [7:0] aa = 8'h00, ra = 8'h00;
  logic [31:0] wd = 32'h0, rd_v, rdat;
  logic [1:0] pin = 2'h0, br_s, rr_s, rsp;
  logic [3:0] line;
  int err_total = 0, compares = 0, frames = 0, ecyc = 0, rows = 0, b, e, f;
  always #20 clk = ~clk;
  // Tally finished images and exposure cycles
  always @(posedge clk)
  begin
    frames += (fdone === 1'b1);
    ecyc += (expo === 1'b1);
    rows += (rstb === 1'b1);
  end
  iatc_top #(.P_RATE_WINDOW(200)) dut (.i_core_clk(clk), .i_rst(rst),
    .i_s_axi_awaddr(aa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_r), .o_s_axi_bresp(br_s), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(br), .i_s_axi_araddr(ra), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rd_v), .o_s_axi_rresp(rr_s),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .i_trig_line(line),
    .o_acquiring(acq), .o_exposing(expo), .o_row_strobe(rstb),
    .o_frame_done(fdone), .o_auto_active(auto));
  iatc_trig_src src (.i_core_clk(clk), .i_fire(fire), .i_pin(pin), .o_line(line));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      err_total++;
      $display("FAIL %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // A used-up wait counts as a mismatch
  task automatic tmo(input int n);
    if (n >= 9000)
    begin
      err_total++;
      end_sim();
    end
  endtask : tmo
  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 9000);
    br <= 1'b0;
    rsp = br_s;
    // Let an edge pass so the next call never re-raises ready in this step
    @(posedge clk);
    tmo(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 9000);
    rr <= 1'b0;
    rdat = rd_v;
    rsp = rr_s;
    @(posedge clk);
    tmo(n);
  endtask : rd
  // Bounded waits on capture activity and image count
  task automatic w_acq(input logic v);
    int n;
    for (n = 0; acq !== v && n < 9000; n++) @(posedge clk);
    tmo(n);
  endtask : w_acq
  task automatic w_frm(input int x);
    int n;
    for (n = 0; frames < x && n < 9000; n++) @(posedge clk);
    tmo(n);
  endtask : w_frm
  initial
  begin
    b = $urandom(32'h45efbe81);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h18);
    chk("trig cfg", rdat, 32'h30);
    rd(8'h24);
    chk("bad rd", {rdat[29:0], rsp}, 32'h2);
    wr(8'h20, 32'h5);
    chk("ro wr", rsp, 32'h2);
    wr(8'h14, 32'h017d7840);
    e = 1 + $urandom % 6;
    wr(8'h0c, e);
    // Single image, auto once, shutter bit must not stick
    wr(8'h00, 32'h112);
    frames = 0;
    ecyc = 0;
    rows = 0;
    wr(8'h04, 32'h1);
    w_acq(1'b1);
    w_acq(1'b0);
    chk("single", frames, 1);
    chk("expose", ecyc, e * 25);
    chk("rows", rows, 32'(iatc_pkg::ROWS_PER_FRAME));
    rd(8'h00);
    chk("ctrl", rdat, 32'h2);
    chk("auto", auto, 0);
    // Burst of random length
    b = 2 + $urandom % 3;
    wr(8'h08, b);
    wr(8'h00, 32'h1);
    frames = 0;
    wr(8'h04, 32'h1);
    w_acq(1'b1);
    w_acq(1'b0);
    chk("multi", frames, b);
    // Continuous until stopped
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1);
    w_frm(b + 3);
    // Wait out two whole rate windows inside the run before reading it
    repeat (400) @(posedge clk);
    rd(8'h20);
    chk("rate", 32'(rdat != 32'h0), 32'h1);
    wr(8'h04, 32'h2);
    w_acq(1'b0);
    f = frames;
    repeat (200) @(posedge clk);
    chk("stopped", frames, f);
    // Pacing on with a zero rate: the pending first slot, then nothing
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h40);
    frames = 0;
    wr(8'h04, 32'h1);
    repeat (400) @(posedge clk);
    chk("paced", frames, 1);
    wr(8'h04, 32'h2);
    // Start trigger holds the burst until the host trigger
    wr(8'h00, 32'h1);
    wr(8'h18, 32'h1);
    frames = 0;
    wr(8'h04, 32'h1);
    repeat (200) @(posedge clk);
    chk("armed", frames, 0);
    wr(8'h04, 32'h4);
    w_acq(1'b0);
    chk("acq trig", frames, b);
    // Per-image triggers in continuous mode
    wr(8'h18, 32'h0);
    wr(8'h00, 32'h80);
    wr(8'h18, 32'h1);
    frames = 0;
    wr(8'h04, 32'h1);
    repeat (200) @(posedge clk);
    chk("no trig", frames, 0);
    wr(8'h04, 32'h4);
    w_frm(1);
    repeat (200) @(posedge clk);
    chk("one image", frames, 1);
    // Every activation from a random pin, level low last
    for (int a = 3; a >= 0; a--)
    begin
      pin <= 2'($urandom % 4);
      f = a * 16 + ($urandom % 4 + 1) * 2 + 1;
      wr(8'h18, 32'(f));
      rd(8'h18);
      chk("trig rb", rdat, 32'(f));
      // Source code is pin plus one, three bits so pin three stays a pin
      wr(8'h18, {26'h0, 2'(a), 3'(pin) + 3'h1, 1'b1});
      f = frames;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      w_frm(f + 1);
    end
    // Pulse-length exposure lasts as long as the three-cycle pulse
    wr(8'h18, {26'h0, 2'h3, 3'(pin) + 3'h1, 1'b1});
    wr(8'h00, 32'h88);
    repeat (200) @(posedge clk);
    ecyc = 0;
    f = frames;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    w_frm(f + 1);
    chk("width expo", ecyc, 3);
    wr(8'h04, 32'h2);
    w_acq(1'b0);
    chk("end", acq, 0);
    end_sim();
  end
endmodule : iatc_top_test
`default_nettype wire

// ### testbench/iatc_trig_src.sv
`default_nettype none
// Far-side trigger lines: idle low, one pulse per fire request
module iatc_trig_src (
  input wire logic i_core_clk,
  input wire logic i_fire,
  input wire logic [1:0] i_pin,
  output logic [3:0] o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_line = 4'h0;
  // Three-cycle high pulse, so both edges and levels are seen
  always @(posedge i_core_clk)
    if (i_fire)
    begin
      o_line[i_pin] <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      o_line[i_pin] <= 1'b0;
    end
endmodule : iatc_trig_src
`default_nettype wire
